// ==== hw/fpc_ctrl.sv ====
// Flash page program control: key launch, page buffer and sequencer
`timescale 1ns/1ps
`default_nettype none

module fpc_ctrl #(
	parameter int BUF_BYTES = 64
)(
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic FCR_WR,
	input wire logic [7:0] FCR_WDATA,
	output logic [7:0] FCR_RDATA,
	input wire logic INSTR_DONE,
	input wire logic EXEC_INTERNAL,
	input wire logic AUTO_ERASE,
	input wire logic EXTERNAL_RAM_SELECT_BIT_SEL,
	input wire logic XWR,
	input wire logic [15:0] XADDR,
	input wire logic [7:0] XWDATA,
	output logic DMEM_WR,
	output logic DMEM_EXT,
	output logic [15:0] DMEM_ADDR,
	output logic [7:0] DMEM_WDATA,
	input wire logic CODE_RD,
	input wire logic [15:0] CODE_ADDR,
	output logic CODE_RVALID,
	output logic [7:0] CODE_RDATA,
	output logic ARR_REQ,
	output fpc_pkg::fpc_arr_s ARR_CMD,
	input wire logic ARR_ACK,
	input wire logic [7:0] ARR_RDATA,
	input wire logic BROWNOUT,
	input wire logic ERR_CLR,
	output logic ERR_FLAG,
	output logic CPU_STALL,
	output logic IRQ_HOLD
);

	localparam int IW = $clog2(BUF_BYTES);
	localparam logic [IW-1:0] IDX_LAST = IW'(BUF_BYTES - 1);

	function automatic fpc_pkg::fpc_map_s map_read(input logic [1:0] sel,
		input logic [15:0] a);
		fpc_pkg::fpc_map_s m;
		m.ok = 1'b1;
		m.space = fpc_pkg::SP_APP;
		if (sel == fpc_pkg::SEL_SIG)
		begin
			m.ok = (a <= fpc_pkg::VSIG_LAST);
			m.space = (a <= fpc_pkg::USIG_LAST) ? fpc_pkg::SP_USIG :
				fpc_pkg::SP_VSIG;
		end
		else if (sel == fpc_pkg::SEL_FUSE)
		begin
			m.ok = (a <= fpc_pkg::SEC_LAST);
			m.space = (a <= fpc_pkg::FUSE_LAST) ? fpc_pkg::SP_UFUSE :
				fpc_pkg::SP_SEC;
		end
		else if (sel == fpc_pkg::SEL_RSVD)
		begin
			m.ok = 1'b0;
		end
		return m;
	endfunction

	logic map_r;
	logic [1:0] sel_r;
	logic busy_r;
	logic armed_r;
	logic seen_r;
	logic stall_r;
	logic err_r;
	logic bo_meta_r;
	logic bo_r;
	logic [7:0] buf_r [BUF_BYTES];
	logic [BUF_BYTES-1:0] loaded_r;
	logic [8:0] page_r;
	logic half_r;
	logic [IW-1:0] idx_r;
	fpc_pkg::fpc_state_e state_r;
	fpc_pkg::fpc_space_e tgt_r;
	logic ae_r;
	logic req_r;
	fpc_pkg::fpc_arr_s cmd_r;
	logic pend_r;
	logic [15:0] caddr_r;
	logic rvalid_r;
	logic [7:0] rdata_r;
	logic dwr_r;
	logic dext_r;
	logic [15:0] daddr_r;
	logic [7:0] dwdata_r;

	logic [3:0] wkey;
	logic [1:0] wsel;
	logic key_arm;
	logic launch;
	fpc_pkg::fpc_map_s cmap;
	logic [15:0] wr_addr;

	assign wkey = FCR_WDATA[fpc_pkg::KEY_MSB:fpc_pkg::KEY_LSB];
	assign wsel = FCR_WDATA[fpc_pkg::SEL_MSB:fpc_pkg::SEL_LSB];
	// Key 5 arms nothing for the reserved select
	assign key_arm = FCR_WR && !busy_r && wkey == fpc_pkg::KEY_ARM &&
		wsel != fpc_pkg::SEL_RSVD;
	assign launch = FCR_WR && !busy_r && armed_r &&
		wkey == fpc_pkg::KEY_GO && wsel != fpc_pkg::SEL_RSVD;
	assign cmap = map_read(sel_r, caddr_r);
	assign wr_addr = {page_r, half_r, idx_r};

	assign FCR_RDATA = {fpc_pkg::KEY_READ, map_r, sel_r, busy_r};
	assign DMEM_WR = dwr_r;
	assign DMEM_EXT = dext_r;
	assign DMEM_ADDR = daddr_r;
	assign DMEM_WDATA = dwdata_r;
	assign CODE_RVALID = rvalid_r;
	assign CODE_RDATA = rdata_r;
	assign ARR_REQ = req_r;
	assign ARR_CMD = cmd_r;
	assign ERR_FLAG = err_r;
	assign CPU_STALL = stall_r;
	assign IRQ_HOLD = stall_r;

	// Map and select bits
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			map_r <= 1'b0;
			sel_r <= fpc_pkg::SEL_APP;
		end
		else if (FCR_WR)
		begin
			map_r <= FCR_WDATA[fpc_pkg::MAP_BIT];
			sel_r <= wsel;
		end
	end

	// Key sequence: only one instruction end, the key 5 write's own, allowed before the key A write
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			armed_r <= 1'b0;
			seen_r <= 1'b0;
		end
		else if (key_arm)
		begin
			armed_r <= 1'b1;
			seen_r <= INSTR_DONE;
		end
		else if (FCR_WR)
		begin
			armed_r <= 1'b0;
			seen_r <= 1'b0;
		end
		else if (armed_r && INSTR_DONE)
		begin
			if (seen_r)
				armed_r <= 1'b0;
			seen_r <= 1'b1;
		end
	end

	// Brown-out synchroniser
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			bo_meta_r <= 1'b0;
			bo_r <= 1'b0;
		end
		else
		begin
			bo_meta_r <= BROWNOUT;
			bo_r <= bo_meta_r;
		end
	end

	// Error flag, set wins over clear
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
			err_r <= 1'b0;
		else if (busy_r && bo_r)
			err_r <= 1'b1;
		else if (ERR_CLR)
			err_r <= 1'b0;
	end

	// Data writes: page buffer or data memory
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			dwr_r <= 1'b0;
			dext_r <= 1'b0;
			daddr_r <= 16'h0000;
			dwdata_r <= 8'h00;
		end
		else
		begin
			dwr_r <= XWR && !map_r;
			if (XWR && !map_r)
			begin
				dext_r <= EXTERNAL_RAM_SELECT_BIT_SEL;
				daddr_r <= XADDR;
				dwdata_r <= XWDATA;
			end
		end
	end

	// Page buffer loading and clearing
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			loaded_r <= '0;
			page_r <= 9'h000;
			half_r <= 1'b0;
		end
		else if (state_r == fpc_pkg::ST_FINISH)
			loaded_r <= '0;
		else if (XWR && map_r && !busy_r)
		begin
			page_r <= XADDR[15:fpc_pkg::PAGE_LSB];
			half_r <= XADDR[fpc_pkg::HALF_BIT];
			loaded_r[XADDR[fpc_pkg::OFS_BITS-1:0]] <= 1'b1;
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (XWR && map_r && !busy_r && !loaded_r[XADDR[fpc_pkg::OFS_BITS-1:0]])
			buf_r[XADDR[fpc_pkg::OFS_BITS-1:0]] <= XWDATA;
	end

	// Busy and CPU stall
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			busy_r <= 1'b0;
			stall_r <= 1'b0;
		end
		else if (launch)
		begin
			busy_r <= 1'b1;
			stall_r <= EXEC_INTERNAL;
		end
		else if (state_r == fpc_pkg::ST_FINISH)
		begin
			busy_r <= 1'b0;
			stall_r <= 1'b0;
		end
	end

	// Code read request capture
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			pend_r <= 1'b0;
			caddr_r <= 16'h0000;
		end
		else if (CODE_RD)
		begin
			pend_r <= 1'b1;
			caddr_r <= CODE_ADDR;
		end
		else if (state_r == fpc_pkg::ST_IDLE && !launch)
			pend_r <= 1'b0;
	end

	// Array sequencer
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state_r <= fpc_pkg::ST_IDLE;
			tgt_r <= fpc_pkg::SP_APP;
			ae_r <= 1'b0;
			idx_r <= '0;
			req_r <= 1'b0;
			cmd_r <= '0;
			rvalid_r <= 1'b0;
			rdata_r <= 8'h00;
		end
		else
		begin
			rvalid_r <= 1'b0;
			if (busy_r && bo_r && state_r != fpc_pkg::ST_FINISH)
			begin
				req_r <= 1'b0;
				state_r <= fpc_pkg::ST_FINISH;
			end
			else
			begin
				case (state_r)
				fpc_pkg::ST_IDLE:
				begin
					idx_r <= '0;
					if (launch)
					begin
						ae_r <= AUTO_ERASE;
						tgt_r <= (wsel == fpc_pkg::SEL_SIG) ? fpc_pkg::SP_USIG :
							(wsel == fpc_pkg::SEL_FUSE) ? fpc_pkg::SP_UFUSE :
							fpc_pkg::SP_APP;
						if (AUTO_ERASE)
						begin
							req_r <= 1'b1;
							cmd_r.op <= fpc_pkg::OP_ERASE;
							cmd_r.space <= (wsel == fpc_pkg::SEL_SIG) ?
								fpc_pkg::SP_USIG : (wsel == fpc_pkg::SEL_FUSE) ?
								fpc_pkg::SP_UFUSE : fpc_pkg::SP_APP;
							cmd_r.addr <= {page_r, 7'h00};
							state_r <= fpc_pkg::ST_ERASE;
						end
						else
							state_r <= fpc_pkg::ST_SCAN;
					end
					else if (pend_r)
					begin
						if (cmap.ok)
						begin
							req_r <= 1'b1;
							cmd_r.op <= fpc_pkg::OP_READ;
							cmd_r.space <= cmap.space;
							cmd_r.addr <= caddr_r;
							state_r <= fpc_pkg::ST_CREAD;
						end
						else
						begin
							rvalid_r <= 1'b1;
							rdata_r <= fpc_pkg::BYTE_ERASED;
						end
					end
				end
				fpc_pkg::ST_CREAD:
					if (ARR_ACK)
					begin
						req_r <= 1'b0;
						rvalid_r <= 1'b1;
						rdata_r <= ARR_RDATA;
						state_r <= fpc_pkg::ST_IDLE;
					end
				fpc_pkg::ST_ERASE:
					if (ARR_ACK)
					begin
						req_r <= 1'b0;
						state_r <= fpc_pkg::ST_SCAN;
					end
				fpc_pkg::ST_SCAN:
					if (loaded_r[idx_r])
					begin
						req_r <= 1'b1;
						cmd_r.space <= tgt_r;
						cmd_r.addr <= wr_addr;
						if (ae_r)
						begin
							cmd_r.op <= fpc_pkg::OP_WRITE;
							cmd_r.wdata <= buf_r[idx_r];
							state_r <= fpc_pkg::ST_WRITE;
						end
						else
						begin
							cmd_r.op <= fpc_pkg::OP_READ;
							state_r <= fpc_pkg::ST_RDOLD;
						end
					end
					else if (idx_r == IDX_LAST)
						state_r <= fpc_pkg::ST_FINISH;
					else
						idx_r <= idx_r + 1'b1;
				fpc_pkg::ST_RDOLD:
					if (ARR_ACK)
					begin
						cmd_r.op <= fpc_pkg::OP_WRITE;
						cmd_r.wdata <= ARR_RDATA & buf_r[idx_r];
						state_r <= fpc_pkg::ST_WRITE;
					end
				fpc_pkg::ST_WRITE:
					if (ARR_ACK)
					begin
						req_r <= 1'b0;
						if (idx_r == IDX_LAST)
							state_r <= fpc_pkg::ST_FINISH;
						else
						begin
							idx_r <= idx_r + 1'b1;
							state_r <= fpc_pkg::ST_SCAN;
						end
					end
				fpc_pkg::ST_FINISH:
					state_r <= fpc_pkg::ST_IDLE;
				default:
					state_r <= fpc_pkg::ST_IDLE;
				endcase
			end
		end
	end

	sequence s_arm;
		FCR_WR && !busy_r && wkey == fpc_pkg::KEY_ARM &&
			wsel != fpc_pkg::SEL_RSVD;
	endsequence

	sequence s_go;
		FCR_WR && !busy_r && wkey == fpc_pkg::KEY_GO &&
			wsel != fpc_pkg::SEL_RSVD;
	endsequence

	key_pair_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		s_arm ##1 s_go |=> busy_r)
		else $error("key pair did not start programming");

	lone_go_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		(FCR_WR && wkey == fpc_pkg::KEY_GO && !armed_r && !busy_r) |=> !busy_r)
		else $error("launch without armed key");

	stall_int_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		(launch && EXEC_INTERNAL) |=> (CPU_STALL && IRQ_HOLD) until !busy_r)
		else $error("internal launch did not stall cpu");

	ext_run_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		(launch && !EXEC_INTERNAL) |=> !CPU_STALL && busy_r)
		else $error("external launch stalled cpu");

	clear_only_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		(req_r && cmd_r.op == fpc_pkg::OP_WRITE) |->
			((cmd_r.wdata | buf_r[idx_r]) == buf_r[idx_r]))
		else $error("program data sets a bit");

	map_route_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		(XWR && map_r) |=> !DMEM_WR)
		else $error("mapped write reached data memory");

	dmem_route_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		(XWR && !map_r) |=> DMEM_WR && DMEM_ADDR == $past(XADDR))
		else $error("data write lost");

	finish_clear_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		(state_r == fpc_pkg::ST_FINISH) |=> loaded_r == '0 && !busy_r)
		else $error("buffer or busy not cleared");

	brownout_err_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		(busy_r && bo_r) |=> ERR_FLAG ##1 !busy_r)
		else $error("brown-out not flagged");

	busy_key_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		(busy_r && FCR_WR) |=> !armed_r && $stable(tgt_r))
		else $error("key write disturbed programming");

endmodule
`default_nettype wire

// ==== hw/fpc_pkg.sv ====
// Constants and types for the flash page program control block
package fpc_pkg;

	// Flash control register layout
	localparam int KEY_MSB = 7;
	localparam int KEY_LSB = 4;
	localparam int MAP_BIT = 3;
	localparam int SEL_MSB = 2;
	localparam int SEL_LSB = 1;
	localparam int BUSY_BIT = 0;
	localparam logic [3:0] KEY_ARM = 4'h5;
	localparam logic [3:0] KEY_GO = 4'ha;
	localparam logic [3:0] KEY_READ = 4'h0;

	// Space select codes
	localparam logic [1:0] SEL_APP = 2'h0;
	localparam logic [1:0] SEL_SIG = 2'h1;
	localparam logic [1:0] SEL_FUSE = 2'h2;
	localparam logic [1:0] SEL_RSVD = 2'h3;

	// Address limits of the mapped read spaces
	localparam logic [15:0] USIG_LAST = 16'h01ff;
	localparam logic [15:0] VSIG_LAST = 16'h027f;
	localparam logic [15:0] FUSE_LAST = 16'h007f;
	localparam logic [15:0] SEC_LAST = 16'h00ff;

	localparam logic [7:0] BYTE_ERASED = 8'hff;
	localparam int OFS_BITS = 6;
	localparam int HALF_BIT = 6;
	localparam int PAGE_LSB = 7;

	// Array spaces
	typedef enum logic [2:0] {
		SP_APP = 3'b000,
		SP_USIG = 3'b001,
		SP_VSIG = 3'b010,
		SP_UFUSE = 3'b011,
		SP_SEC = 3'b100
	} fpc_space_e;

	typedef enum logic [1:0] {
		OP_READ = 2'b00,
		OP_ERASE = 2'b01,
		OP_WRITE = 2'b10
	} fpc_op_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ERASE = 3'b001,
		ST_SCAN = 3'b010,
		ST_RDOLD = 3'b011,
		ST_WRITE = 3'b100,
		ST_FINISH = 3'b101,
		ST_CREAD = 3'b110
	} fpc_state_e;

	// Request to the flash array
	typedef struct packed {
		fpc_op_e op;
		fpc_space_e space;
		logic [15:0] addr;
		logic [7:0] wdata;
	} fpc_arr_s;

	// Result of mapping a code read
	typedef struct packed {
		logic ok;
		fpc_space_e space;
	} fpc_map_s;

endpackage

// ==== tb/fpc_flash_model.sv ====
// Behavioural flash array answering the sequencer's requests
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_model (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic ARR_REQ,
	input wire fpc_pkg::fpc_arr_s ARR_CMD,
	output logic ARR_ACK,
	output logic [7:0] ARR_RDATA
);
	logic [7:0] mem [logic [18:0]];

	function automatic logic [7:0] rd(input logic [18:0] k);
		return mem.exists(k) ? mem[k] : 8'hff;
	endfunction

	task automatic poke(input logic [2:0] sp, input logic [15:0] a,
		input logic [7:0] v);
		mem[{sp, a}] = v;
	endtask

	// Random wait of 0 to 2 cycles before each answer
	initial
	begin
		logic [18:0] k;
		ARR_ACK = 1'b0;
		ARR_RDATA = 8'h00;
		forever
		begin
			@(posedge CLOCK);
			if (RSTN === 1'b1 && ARR_REQ === 1'b1)
			begin
				repeat ($urandom_range(2, 0)) @(posedge CLOCK);
				// A request withdrawn meanwhile is not served
				if (ARR_REQ === 1'b1)
				begin
					k = {ARR_CMD.space, ARR_CMD.addr};
					ARR_ACK <= 1'b1;
					case (ARR_CMD.op)
					fpc_pkg::OP_READ: ARR_RDATA <= rd(k);
					fpc_pkg::OP_WRITE: mem[k] = rd(k) & ARR_CMD.wdata;
					fpc_pkg::OP_ERASE:
						for (int i = 0; i < 128; i++)
							mem[{k[18:7], i[6:0]}] = 8'hff;
					default: ;
					endcase
					@(posedge CLOCK);
					ARR_ACK <= 1'b0;
					ARR_RDATA <= ~ARR_RDATA;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/fpc_ctrl_tb.sv ====
// Self-checking bench for the flash page program control block
`timescale 1ns/1ps
`default_nettype none
module fpc_ctrl_tb;
	logic CLOCK, RSTN, FCR_WR, INSTR_DONE, EXEC_INTERNAL, AUTO_ERASE;
	logic EXTERNAL_RAM_SELECT_BIT_SEL, XWR, CODE_RD, ARR_ACK, BROWNOUT, ERR_CLR, map_v;
	logic DMEM_WR, DMEM_EXT, CODE_RVALID, ARR_REQ, ERR_FLAG;
	logic CPU_STALL, IRQ_HOLD;
	logic [7:0] FCR_WDATA, FCR_RDATA, XWDATA, DMEM_WDATA, CODE_RDATA;
	logic [7:0] ARR_RDATA;
	logic [15:0] XADDR, DMEM_ADDR, CODE_ADDR;
	fpc_pkg::fpc_arr_s ARR_CMD;
	logic [7:0] code_q [$];
	logic [24:0] dmem_q [$];
	logic [7:0] old_v [4];
	logic [7:0] new_v [4];
	logic [5:0] ofs [4];
	logic [26:0] tbl [9];
	logic [1:0] sq [3];
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;
	logic [24:0] exp_v;

	fpc_ctrl fpc_ctrl_i (.CLOCK(CLOCK), .RSTN(RSTN), .FCR_WR(FCR_WR),
		.FCR_WDATA(FCR_WDATA), .FCR_RDATA(FCR_RDATA),
		.INSTR_DONE(INSTR_DONE), .EXEC_INTERNAL(EXEC_INTERNAL),
		.AUTO_ERASE(AUTO_ERASE), .EXTERNAL_RAM_SELECT_BIT_SEL(EXTERNAL_RAM_SELECT_BIT_SEL), .XWR(XWR),
		.XADDR(XADDR), .XWDATA(XWDATA), .DMEM_WR(DMEM_WR),
		.DMEM_EXT(DMEM_EXT), .DMEM_ADDR(DMEM_ADDR),
		.DMEM_WDATA(DMEM_WDATA), .CODE_RD(CODE_RD), .CODE_ADDR(CODE_ADDR),
		.CODE_RVALID(CODE_RVALID), .CODE_RDATA(CODE_RDATA),
		.ARR_REQ(ARR_REQ), .ARR_CMD(ARR_CMD), .ARR_ACK(ARR_ACK),
		.ARR_RDATA(ARR_RDATA), .BROWNOUT(BROWNOUT), .ERR_CLR(ERR_CLR),
		.ERR_FLAG(ERR_FLAG), .CPU_STALL(CPU_STALL), .IRQ_HOLD(IRQ_HOLD));

	fpc_flash_model fpc_flash_model_i (.CLOCK(CLOCK), .RSTN(RSTN),
		.ARR_REQ(ARR_REQ), .ARR_CMD(ARR_CMD), .ARR_ACK(ARR_ACK),
		.ARR_RDATA(ARR_RDATA));

	task automatic chk(input string name, input logic [24:0] seen,
		input logic [24:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Control write; l releases the strobe, else the next write follows
	task automatic fcr(input logic [7:0] d, input logic l);
		@(posedge CLOCK);
		FCR_WR <= 1'b1;
		FCR_WDATA <= d;
		INSTR_DONE <= 1'b1;
		map_v = d[3];
		if (l)
		begin
			@(posedge CLOCK);
			FCR_WR <= 1'b0;
			INSTR_DONE <= 1'b0;
		end
	endtask

	task automatic instr();
		@(posedge CLOCK);
		INSTR_DONE <= 1'b1;
		@(posedge CLOCK);
		INSTR_DONE <= 1'b0;
	endtask

	task automatic xwr(input logic [15:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		XWR <= 1'b1;
		XADDR <= a;
		XWDATA <= d;
		if (!map_v)
			dmem_q.push_back({EXTERNAL_RAM_SELECT_BIT_SEL, a, d});
		@(posedge CLOCK);
		XWR <= 1'b0;
	endtask

	task automatic cread(input logic [15:0] a, input logic [7:0] e);
		@(posedge CLOCK);
		CODE_RD <= 1'b1;
		CODE_ADDR <= a;
		code_q.push_back(e);
		@(posedge CLOCK);
		CODE_RD <= 1'b0;
		for (int i = 0; i < 60 && code_q.size() != 0; i++)
			@(posedge CLOCK);
	endtask

	// Mode 1 browns out mid-write, mode 2 repeats the keys while busy
	task automatic launch(input logic [1:0] s, input int m);
		logic e;
		fcr({fpc_pkg::KEY_ARM, 1'b0, s, 1'b0}, 1'b0);
		fcr({fpc_pkg::KEY_GO, 1'b0, s, 1'b0}, 1'b1);
		@(negedge CLOCK);
		// Execution place as the launch edge saw it
		e = EXEC_INTERNAL & (s != 2'h3);
		chk("busy", FCR_RDATA[0], s != 2'h3);
		chk("stall", {CPU_STALL, IRQ_HOLD}, {e, e});
		@(posedge CLOCK);
		BROWNOUT <= (m == 1);
		for (int i = 0; i < 3000 && FCR_RDATA[0] === 1'b1; i++)
		begin
			if (m == 2 && i == 3)
			begin
				fcr(8'h50, 1'b0);
				fcr(8'ha0, 1'b1);
			end
			@(negedge CLOCK);
		end
		@(posedge CLOCK);
		BROWNOUT <= 1'b0;
		repeat (4) @(negedge CLOCK);
		chk("idle", {FCR_RDATA[0], CPU_STALL}, 2'h0);
	endtask

	initial
	begin
		CLOCK = 1'b0;
		forever #25 CLOCK = ~CLOCK;
	end

	always @(posedge CLOCK)
	begin
		cycles <= cycles + 1;
		if (CODE_RVALID === 1'b1)
		begin
			exp_v = code_q.size() ? code_q.pop_front() : 9'h100;
			chk("code", CODE_RDATA, exp_v);
		end
		if (DMEM_WR === 1'b1)
		begin
			exp_v = dmem_q.size() ? dmem_q.pop_front() : 25'h1ffffff;
			chk("dmem", {DMEM_EXT, DMEM_ADDR, DMEM_WDATA}, exp_v);
		end
		if (cycles == 20000)
		begin
			fail_count++;
			final_report();
		end
	end

	initial
	begin
		{RSTN, FCR_WR, INSTR_DONE, EXEC_INTERNAL, AUTO_ERASE} = '0;
		{EXTERNAL_RAM_SELECT_BIT_SEL, XWR, CODE_RD, BROWNOUT, ERR_CLR, map_v} = '0;
		{FCR_WDATA, XWDATA, XADDR, CODE_ADDR} = '0;
		void'($urandom(29735));
		repeat (4) @(posedge CLOCK);
		RSTN <= 1'b1;
		@(negedge CLOCK);
		chk("reset", {FCR_RDATA, ERR_FLAG, CPU_STALL, ARR_REQ}, 11'h0);
		fcr(8'h0e, 1'b1);
		@(negedge CLOCK);
		chk("fcr read", FCR_RDATA, 8'h0e);
		for (int i = 0; i < 2; i++)
		begin
			fcr(8'h00, 1'b1);
			EXTERNAL_RAM_SELECT_BIT_SEL <= i[0];
			xwr(16'($urandom), 8'($urandom));
		end
		// Mapped space reads, with table rows {map, sel, addr, data}
		fpc_flash_model_i.poke(fpc_pkg::SP_APP, 16'h0010, 8'h55);
		fpc_flash_model_i.poke(fpc_pkg::SP_USIG, 16'h0010, 8'h11);
		fpc_flash_model_i.poke(fpc_pkg::SP_VSIG, 16'h0210, 8'h22);
		fpc_flash_model_i.poke(fpc_pkg::SP_VSIG, 16'h0010, 8'h22);
		fpc_flash_model_i.poke(fpc_pkg::SP_UFUSE, 16'h0005, 8'h33);
		fpc_flash_model_i.poke(fpc_pkg::SP_SEC, 16'h0085, 8'h44);
		fpc_flash_model_i.poke(fpc_pkg::SP_SEC, 16'h0005, 8'h44);
		tbl = '{{3'h0, 16'h0010, 8'h55}, {3'h1, 16'h0010, 8'h11},
			{3'h1, 16'h0210, 8'h22}, {3'h1, 16'h0280, 8'hff},
			{3'h2, 16'h0005, 8'h33}, {3'h2, 16'h0085, 8'h44},
			{3'h2, 16'h0100, 8'hff}, {3'h3, 16'h0010, 8'hff},
			{3'h4, 16'h0010, 8'h55}};
		for (int i = 0; i < 9; i++)
		begin
			fcr({4'h0, tbl[i][26:24], 1'b0}, 1'b1);
			cread(tbl[i][23:8], tbl[i][7:0]);
		end
		// Partial half-page write over old data, launched internally
		ofs = '{6'h00, 6'h05, 6'h3f, 6'h09};
		for (int i = 0; i < 4; i++)
		begin
			old_v[i] = 8'($urandom);
			new_v[i] = 8'($urandom);
			fpc_flash_model_i.poke(fpc_pkg::SP_APP, 16'h02c0 + ofs[i], old_v[i]);
		end
		fpc_flash_model_i.poke(fpc_pkg::SP_APP, 16'h0285, 8'h5a);
		fcr(8'h08, 1'b1);
		EXTERNAL_RAM_SELECT_BIT_SEL <= 1'b1;
		for (int i = 0; i < 3; i++)
			xwr(16'h02c0 + ofs[i], new_v[i]);
		xwr(16'h02c5, ~new_v[1]);
		fcr(8'h00, 1'b1);
		EXEC_INTERNAL <= 1'b1;
		launch(fpc_pkg::SEL_APP, 2);
		for (int i = 0; i < 3; i++)
			cread(16'h02c0 + ofs[i], old_v[i] & new_v[i]);
		cread(16'h02c9, old_v[3]);
		cread(16'h0285, 8'h5a);
		// External launches with auto-erase; CPU_STALL and IRQ_HOLD stay low
		EXEC_INTERNAL <= 1'b0;
		AUTO_ERASE <= 1'b1;
		launch(fpc_pkg::SEL_APP, 0);
		cread(16'h02c0, 8'hff);
		cread(16'h0285, 8'hff);
		fpc_flash_model_i.poke(fpc_pkg::SP_APP, 16'h0284, 8'h00);
		fpc_flash_model_i.poke(fpc_pkg::SP_APP, 16'h02c5, 8'h00);
		fcr(8'h08, 1'b1);
		xwr(16'h0283, new_v[0]);
		fcr(8'h00, 1'b1);
		launch(fpc_pkg::SEL_APP, 0);
		cread(16'h0283, new_v[0]);
		cread(16'h0284, 8'hff);
		cread(16'h02c5, 8'hff);
		// Extra instruction between the keys aborts the launch
		AUTO_ERASE <= 1'b0;
		fpc_flash_model_i.poke(fpc_pkg::SP_APP, 16'h0300, 8'hf0);
		fcr(8'h08, 1'b1);
		xwr(16'h0300, 8'h0f);
		fcr(8'h00, 1'b1);
		fcr(8'h50, 1'b1);
		instr();
		fcr(8'ha0, 1'b1);
		@(negedge CLOCK);
		chk("abort", FCR_RDATA[0], 1'b0);
		cread(16'h0300, 8'hf0);
		launch(fpc_pkg::SEL_APP, 0);
		cread(16'h0300, 8'h00);
		// Reserved, signature and fuse targets
		sq = '{fpc_pkg::SEL_RSVD, fpc_pkg::SEL_SIG, fpc_pkg::SEL_FUSE};
		for (int i = 0; i < 3; i++)
		begin
			fcr({4'h0, 1'b1, sq[i], 1'b0}, 1'b1);
			xwr(16'h0020, 8'h3c);
			fcr({4'h0, 1'b0, sq[i], 1'b0}, 1'b1);
			launch(sq[i], 0);
			cread(16'h0020, i ? 8'h3c : 8'hff);
		end
		// Brown-out in mid-write
		fcr(8'h08, 1'b1);
		xwr(16'h0400, 8'h00);
		fcr(8'h00, 1'b1);
		launch(fpc_pkg::SEL_APP, 1);
		chk("err", ERR_FLAG, 1'b1);
		@(posedge CLOCK);
		ERR_CLR <= 1'b1;
		@(posedge CLOCK);
		ERR_CLR <= 1'b0;
		@(negedge CLOCK);
		chk("err clr", ERR_FLAG, 1'b0);
		chk("left", code_q.size() + dmem_q.size(), 0);
		final_report();
	end
endmodule
`default_nettype wire
